/* File: verilog/ssl_top.sv */
// status outputs and torque-mode speed limit of the servo drive
`timescale 1ns/1ps

// How it works
// - done out high in position control when absolute error is below done width
// - done width 0..1073741824, reset 7, used at once
// - timing select: error only, plus filtered ref zero, plus ref input zero
// - close out high while error below close width 1..1073741824, reset max
// - each status output high (closed) when true, low (open) when false
// - clamp out high when speed reaches applied limit, low with no limit
// - source select: internal ceiling or commanded ceiling, latched at restart
// - internal ceiling 0..10000 rpm, reset 10000, used at once
// - basis select: min of internal ceiling with max speed or overspeed speed
// - external mode uses commanded ceiling in torque control
module ssl_top
    import ssl_pkg::*;
(
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RST,
    input  wire logic                  I_RESTART,
    input  wire logic                  I_POS_CTRL,
    input  wire logic                  I_TORQUE_CTRL,
    input  wire logic signed [31:0]    I_POS_ERROR,
    input  wire logic signed [31:0]    I_FILT_REF,
    input  wire logic signed [31:0]    I_REF_INPUT,
    input  wire logic signed [15:0]    I_MOTOR_SPEED,
    input  wire logic [15:0]           I_MAX_SPEED,
    input  wire logic [15:0]           I_OVERSPEED,
    input  wire logic [15:0]           I_COMMANDED_SPEED_CEILING,
    input  wire logic [ssl_pkg::AW-1:0] I_ADDR,
    input  wire logic [31:0]           I_WDATA,
    input  wire logic                  I_WR,
    input  wire logic                  I_RD,
    output logic [31:0]                O_RDATA,
    output logic                       O_POSITIONING_DONE_OUT,
    output logic                       O_CLOSE_OUT,
    output logic                       O_SPEED_CLAMP_ACTIVE_OUT,
    output logic [15:0]                O_APPLIED_CEILING,
    output logic                       O_IRQ
);
    import ssl_pkg::*;

    typedef struct packed {
        logic [30:0] done_width;
        logic [30:0] close_width;
        logic [15:0] int_ceil;
        logic [3:0]  cfg_sw;
        logic [3:0]  cfg_act;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [2:0]  outs;
        logic [15:0] applied;
        logic [31:0] rdata;
    } ssl_state_s;

    ssl_state_s cur_ff;
    ssl_state_s nxt_st;

    logic [31:0] abs_err;
    logic [15:0] abs_spd;
    logic [15:0] basis;
    logic [15:0] lim;
    logic        done_c;
    logic        close_c;
    logic        clamp_c;
    logic [2:0]  outs_c;
    logic [2:0]  rise;
    logic [2:0]  wr_clr;
    ssl_timing_e tsel;

    always_comb begin
        abs_err = I_POS_ERROR[31] ? 32'(-I_POS_ERROR) : I_POS_ERROR;
        abs_spd = I_MOTOR_SPEED[15] ? 16'(-I_MOTOR_SPEED) : I_MOTOR_SPEED;
        tsel    = ssl_timing_e'(cur_ff.cfg_act[CFG_TIMING_LSB +: 2]);
        done_c  = I_POS_CTRL && (abs_err < {1'b0, cur_ff.done_width});
        unique case (tsel)
            DT_ERROR_ONLY: done_c = done_c;
            DT_FILTERED:   done_c = done_c && (I_FILT_REF == 32'h0000_0000);
            DT_REF_INPUT:  done_c = done_c && (I_REF_INPUT == 32'h0000_0000);
            default:       done_c = done_c;
        endcase
        close_c = abs_err < {1'b0, cur_ff.close_width};
        basis = cur_ff.cfg_act[CFG_BASIS_BIT] ? I_OVERSPEED : I_MAX_SPEED;
        if (cur_ff.cfg_act[CFG_SOURCE_BIT]) begin
            lim = I_COMMANDED_SPEED_CEILING;
        end else begin
            lim = (cur_ff.int_ceil < basis) ? cur_ff.int_ceil : basis;
        end
        // limit reached, only while limiting in torque control
        clamp_c = I_TORQUE_CTRL && (abs_spd >= lim);
        outs_c  = {clamp_c, close_c, done_c};
    end

    // rising edges of the three outputs are the interrupt events
    assign rise = outs_c & ~cur_ff.outs;

    always_comb begin
        nxt_st = cur_ff;
        wr_clr = 3'h0;
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.outs    = outs_c;
        nxt_st.applied = I_TORQUE_CTRL ? lim : 16'h0000;
        if (I_RESTART) begin
            nxt_st.cfg_act = cur_ff.cfg_sw;
        end
        if (I_WR) begin
            unique case (I_ADDR)
                REG_DONE_WIDTH: begin
                    nxt_st.done_width = (I_WDATA > {1'b0, WIDTH_MAX}) ? WIDTH_MAX
                                                                      : I_WDATA[30:0];
                end
                REG_CLOSE_WIDTH: begin
                    if (I_WDATA > {1'b0, WIDTH_MAX}) begin
                        nxt_st.close_width = WIDTH_MAX;
                    end else if (I_WDATA == 32'h0000_0000) begin
                        nxt_st.close_width = CLOSE_WIDTH_MIN;
                    end else begin
                        nxt_st.close_width = I_WDATA[30:0];
                    end
                end
                REG_INT_CEIL: begin
                    nxt_st.int_ceil = (I_WDATA > {16'h0000, INT_CEIL_MAX}) ? INT_CEIL_MAX
                                                                         : I_WDATA[15:0];
                end
                REG_CONFIG: begin
                    // timing code 3 is not defined; keep it at 0
                    nxt_st.cfg_sw = I_WDATA[3:0];
                    if (I_WDATA[1:0] == 2'b11) begin
                        nxt_st.cfg_sw[1:0] = 2'b00;
                    end
                end
                REG_IRQ_STAT: wr_clr = I_WDATA[2:0];
                REG_IRQ_MASK: nxt_st.irq_mask = I_WDATA[2:0];
                default: ;
            endcase
        end
        // new event wins over a same-cycle clear
        nxt_st.irq_stat = (cur_ff.irq_stat & ~wr_clr) | rise;
        if (I_RD) begin
            unique case (I_ADDR)
                REG_DONE_WIDTH:  nxt_st.rdata = {1'b0, cur_ff.done_width};
                REG_CLOSE_WIDTH: nxt_st.rdata = {1'b0, cur_ff.close_width};
                REG_INT_CEIL:    nxt_st.rdata = {16'h0000, cur_ff.int_ceil};
                REG_CONFIG:      nxt_st.rdata = {24'h0, cur_ff.cfg_act, cur_ff.cfg_sw};
                REG_STATUS:      nxt_st.rdata = {29'h0, cur_ff.outs};
                REG_IRQ_STAT:    nxt_st.rdata = {29'h0, cur_ff.irq_stat};
                REG_IRQ_MASK:    nxt_st.rdata = {29'h0, cur_ff.irq_mask};
                REG_APPLIED:     nxt_st.rdata = {16'h0000, cur_ff.applied};
                default:         nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            cur_ff <= '{done_width: DONE_WIDTH_RST, close_width: CLOSE_WIDTH_RST,
                        int_ceil: INT_CEIL_RST, cfg_sw: CONFIG_RST, cfg_act: CONFIG_RST,
                        irq_stat: 3'h0, irq_mask: IRQ_MASK_RST, outs: 3'h0,
                        applied: 16'h0000, rdata: 32'h0000_0000};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign O_POSITIONING_DONE_OUT   = cur_ff.outs[0];
    assign O_CLOSE_OUT              = cur_ff.outs[1];
    assign O_SPEED_CLAMP_ACTIVE_OUT = cur_ff.outs[2];
    assign O_APPLIED_CEILING        = cur_ff.applied;
    assign O_RDATA                  = cur_ff.rdata;
    assign O_IRQ                    = |(cur_ff.irq_stat & cur_ff.irq_mask);
endmodule : ssl_top

/* File: verilog/ssl_pkg.sv */
// constants and register map of the servo status and speed-limit block
package ssl_pkg;
    localparam int unsigned POS_W = 32;
    localparam int unsigned SPD_W = 16;
    localparam int unsigned AW    = 4;

    // widths are 31 bits: 0 .. 1073741824 (close width 1 .. 1073741824)
    localparam logic [30:0] DONE_WIDTH_RST  = 31'h0000_0007;
    localparam logic [30:0] CLOSE_WIDTH_RST = 31'h4000_0000;
    localparam logic [30:0] CLOSE_WIDTH_MIN = 31'h0000_0001;
    localparam logic [30:0] WIDTH_MAX       = 31'h4000_0000;
    localparam logic [15:0] INT_CEIL_RST    = 16'h2710;
    localparam logic [15:0] INT_CEIL_MAX    = 16'h2710;

    // register offsets
    localparam logic [3:0] REG_DONE_WIDTH  = 4'h0;
    localparam logic [3:0] REG_CLOSE_WIDTH = 4'h1;
    localparam logic [3:0] REG_INT_CEIL    = 4'h2;
    localparam logic [3:0] REG_CONFIG      = 4'h3;
    localparam logic [3:0] REG_STATUS      = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT    = 4'h5;
    localparam logic [3:0] REG_IRQ_MASK    = 4'h6;
    localparam logic [3:0] REG_APPLIED     = 4'h7;

    // config fields: [1:0] timing, [2] source, [3] basis
    localparam int unsigned CFG_TIMING_LSB = 0;
    localparam int unsigned CFG_SOURCE_BIT = 2;
    localparam int unsigned CFG_BASIS_BIT  = 3;
    localparam logic [3:0]  CONFIG_RST     = 4'h0;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

    typedef enum logic [1:0] {
        DT_ERROR_ONLY = 2'b00,
        DT_FILTERED   = 2'b01,
        DT_REF_INPUT  = 2'b10
    } ssl_timing_e;
endpackage : ssl_pkg

/* File: verification/ssl_monitor.sv */
// port assertions of the status and speed-limit block
`timescale 1ns/1ps
module ssl_monitor (
    input wire logic               I_CLOCK,
    input wire logic               I_RST,
    input wire logic               I_POS_CTRL,
    input wire logic               I_TORQUE_CTRL,
    input wire logic signed [31:0] I_POS_ERROR,
    input wire logic [3:0]         I_ADDR,
    input wire logic               I_RD,
    input wire logic [31:0]        O_RDATA,
    input wire logic               O_POSITIONING_DONE_OUT,
    input wire logic               O_CLOSE_OUT,
    input wire logic               O_SPEED_CLAMP_ACTIVE_OUT,
    input wire logic [15:0]        O_APPLIED_CEILING
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    property p_dm; !I_POS_CTRL |=> !O_POSITIONING_DONE_OUT; endproperty
    a_dm: assert property (p_dm) else $error("done high outside position control");
    property p_cm; !I_TORQUE_CTRL |=> !O_SPEED_CLAMP_ACTIVE_OUT && O_APPLIED_CEILING == 16'h0; endproperty
    a_cm: assert property (p_cm) else $error("limit applied outside torque control");
    property p_df; I_POS_ERROR > 32'sh4000_0000 |=> !O_POSITIONING_DONE_OUT; endproperty
    a_df: assert property (p_df) else $error("done high on huge error");
    property p_cf; I_POS_ERROR >= 32'sh4000_0000 |=> !O_CLOSE_OUT; endproperty
    a_cf: assert property (p_cf) else $error("close high on huge error");
    property p_cz; I_POS_ERROR == 32'sh0 |=> O_CLOSE_OUT; endproperty
    a_cz: assert property (p_cz) else $error("close low on zero error");
    property p_ri; !I_RD |=> O_RDATA == 32'h0; endproperty
    a_ri: assert property (p_ri) else $error("read data outside read slot");
    property p_st; I_RD && I_ADDR == 4'h4 |=> O_RDATA == {29'h0, $past(O_SPEED_CLAMP_ACTIVE_OUT),
        $past(O_CLOSE_OUT), $past(O_POSITIONING_DONE_OUT)}; endproperty
    a_st: assert property (p_st) else $error("status word differs from pins");
    property p_ap; I_RD && I_ADDR == 4'h7 |=> O_RDATA == {16'h0, $past(O_APPLIED_CEILING)}; endproperty
    a_ap: assert property (p_ap) else $error("applied word differs from pins");
    cover property ($rose(O_POSITIONING_DONE_OUT));
    cover property ($rose(O_SPEED_CLAMP_ACTIVE_OUT));
    cover property (I_RD && I_ADDR == 4'h4);
endmodule : ssl_monitor

/* File: verification/ssl_host.sv */
// host model: hands the drive its position error
`timescale 1ns/1ps
module ssl_host (
    input  wire logic signed [31:0] i_ref_count,
    input  wire logic signed [31:0] i_travel,
    output logic signed [31:0]      o_pos_error
);
    assign o_pos_error = i_ref_count - i_travel;
endmodule : ssl_host

/* File: verification/tb_ssl_top.sv */
// self-checking bench of the status and speed-limit block
`timescale 1ns/1ps
module tb_ssl_top;
    import ssl_pkg::*;
    typedef struct {logic p, t; logic signed [31:0] e; logic signed [15:0] s;
        logic [15:0] m; logic [18:0] x;} ssl_row_s;
    logic I_CLOCK = 0, I_RST = 1, I_RESTART = 0, I_POS_CTRL = 0, I_TORQUE_CTRL = 0;
    logic I_WR = 0, I_RD = 0, O_POSITIONING_DONE_OUT, O_CLOSE_OUT, O_SPEED_CLAMP_ACTIVE_OUT, O_IRQ;
    logic signed [31:0] rc = 0, tv = 0, I_POS_ERROR, I_FILT_REF = 0, I_REF_INPUT = 0;
    logic signed [15:0] I_MOTOR_SPEED = 0;
    logic [15:0] I_MAX_SPEED = 0, I_OVERSPEED = 0, I_COMMANDED_SPEED_CEILING = 0, O_APPLIED_CEILING;
    logic [3:0]  I_ADDR = 0;
    logic [31:0] I_WDATA = 0, O_RDATA;
    int fail_count = 0, total_checks = 0;
    // close width left above done width
    ssl_row_s rows[8] = '{'{1, 0, 6, 0, 0, 19'h60000}, '{1, 0, 7, 0, 0, 19'h20000},
        '{1, 0, -6, 0, 0, 19'h60000}, '{0, 0, 0, 0, 0, 19'h20000},
        '{0, 1, 0, 3000, 3000, {3'b011, 16'd3000}}, '{0, 1, 0, -2999, 3000, {3'b010, 16'd3000}},
        '{0, 1, 0, 10000, 12000, {3'b011, 16'd10000}}, '{1, 0, 32'sh4000_0000, 0, 0, 19'h0}};
    always #10 I_CLOCK = ~I_CLOCK;
    ssl_host host_u (.i_ref_count(rc), .i_travel(tv), .o_pos_error(I_POS_ERROR));
    ssl_top dut_u (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge I_CLOCK);
        {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
        @(posedge I_CLOCK);
        I_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge I_CLOCK);
        {I_RD, I_ADDR} <= {1'b1, a};
        @(posedge I_CLOCK);
        I_RD <= 1'b0;
        #1 chk(O_RDATA, exp);
    endtask : rd
    // inputs held two edges so any pipeline depth up to two settles
    task automatic drive(input ssl_row_s r);
        @(posedge I_CLOCK);
        {I_RESTART, I_POS_CTRL, I_TORQUE_CTRL, I_MOTOR_SPEED, I_MAX_SPEED} <= {1'b0, r.p, r.t, r.s, r.m};
        rc <= r.e + 32'sd5;
        tv <= 32'sd5;
        repeat (2) @(posedge I_CLOCK);
        #1 chk({O_POSITIONING_DONE_OUT, O_CLOSE_OUT, O_SPEED_CLAMP_ACTIVE_OUT, O_APPLIED_CEILING}, r.x);
    endtask : drive
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        repeat (12) @(posedge I_CLOCK);
        chk({O_POSITIONING_DONE_OUT, O_CLOSE_OUT, O_SPEED_CLAMP_ACTIVE_OUT, O_IRQ}, 0);
        I_RST <= 1'b0;
        rd(REG_DONE_WIDTH, 7);
        rd(REG_CLOSE_WIDTH, 32'h4000_0000);
        rd(REG_INT_CEIL, 32'h2710);
        rd(4'hf, 0);
        $display("reset values done");
        foreach (rows[i]) drive(rows[i]);
        chk(O_IRQ, 0);
        $display("table done");
        wr(REG_DONE_WIDTH, 0);
        drive('{1, 0, 0, 0, 0, 19'h20000});
        wr(REG_DONE_WIDTH, 32'hffff_ffff);
        rd(REG_DONE_WIDTH, 32'h4000_0000);
        drive('{1, 0, 32'sh4000_0001, 0, 0, 19'h0});
        wr(REG_CONFIG, 32'h6);
        {I_REF_INPUT, I_COMMANDED_SPEED_CEILING, I_RESTART} <= {32'sd5, 16'd500, 1'b1};
        drive('{1, 1, 0, 500, 3000, {3'b011, 16'd500}});
        @(posedge I_CLOCK);
        I_REF_INPUT <= 0;
        drive('{1, 1, 0, 0, 3000, {3'b110, 16'd500}});
        wr(REG_CONFIG, 32'h9);
        {I_FILT_REF, I_OVERSPEED, I_RESTART} <= {32'sd3, 16'd800, 1'b1};
        drive('{1, 1, 0, 800, 3000, {3'b011, 16'd800}});
        rd(REG_CONFIG, 32'h99);
        // undefined timing code is stored as zero
        wr(REG_CONFIG, 32'hb);
        rd(REG_CONFIG, 32'h98);
        wr(REG_INT_CEIL, 100);
        drive('{0, 1, 0, -100, 3000, {3'b011, 16'd100}});
        $display("modes done");
        wr(REG_IRQ_MASK, 1);
        wr(REG_IRQ_STAT, 7);
        I_FILT_REF <= 0;
        drive('{1, 0, 0, 0, 0, 19'h60000});
        chk(O_IRQ, 1);
        rd(REG_IRQ_STAT, 1);
        wr(REG_IRQ_STAT, 1);
        #1 chk(O_IRQ, 0);
        $display("interrupt done");
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge I_CLOCK);
        fail_count++;
        finish_test;
    end
endmodule : tb_ssl_top
bind ssl_top ssl_monitor mon_u (.*);
